// file: common/wd_pkg.sv
// Shared constants and types for the watchdog timer.
package wd_pkg;
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STAT    = 12'h004;
  localparam logic [11:0] ADDR_MASK    = 12'h008;
  localparam logic [11:0] ADDR_RSRC    = 12'h00C;
  localparam int          CE_POS       = 4;
  localparam int          EN_POS       = 3;
  localparam int          PS_W         = 3;
  localparam logic [2:0]  PS_RESET     = 3'h0;
  localparam logic [2:0]  WIN_CYCLES   = 3'h4;
  localparam int          OSC_FREQ_HZ  = 1000000;
  localparam int          TIMEOUT_BASE = 16384;
  localparam int          CNT_W        = 22;
  localparam int          STAT_TMO     = 0;
  localparam int          RSRC_WD      = 0;

  typedef enum logic [1:0] {
    LEVEL0,
    LEVEL1,
    LEVEL2
  } safety_t;

  // A fuse input is high while that fuse is programmed.
  function automatic safety_t level_of(input logic compatProg, input logic alwaysOnProg);
    safety_t lvl;
    lvl = LEVEL1;
    if (alwaysOnProg) begin
      lvl = LEVEL2;
    end else if (compatProg) begin
      lvl = LEVEL0;
    end
    return lvl;
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    return (addr == ADDR_CTRL) || (addr == ADDR_STAT) ||
           (addr == ADDR_MASK) || (addr == ADDR_RSRC);
  endfunction
endpackage

// file: design/wd_change_window.sv
// Four-cycle window that opens the protected watchdog settings.
`timescale 1ns/1ns
`default_nettype none
module wd_change_window (
  input  wire logic clk_sys,    // System clock.
  input  wire logic sys_rst,    // Synchronous reset, active high.
  input  wire logic clrReq,     // Chip reset, closes the window.
  input  wire logic openReq,    // Unlock write seen.
  input  wire logic closeReq,   // Protected write consumed the window.
  output logic      windowOpen  // Change-enable bit as software reads it.
);
  logic [2:0] winCnt_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clrReq) begin
      winCnt_r <= 3'h0;
    end else if (openReq) begin
      winCnt_r <= wd_pkg::WIN_CYCLES;
    end else if (closeReq) begin
      winCnt_r <= 3'h0;
    end else if (winCnt_r != 3'h0) begin
      winCnt_r <= winCnt_r - 3'h1;
    end
  end

  assign windowOpen = (winCnt_r != 3'h0);
endmodule
`default_nettype wire

// file: design/wd_period_counter.sv
// Time-out counter that runs on ticks of the watchdog oscillator.
`timescale 1ns/1ns
`default_nettype none
module wd_period_counter #(
  parameter int TIMEOUT_BASE_P = wd_pkg::TIMEOUT_BASE
) (
  input  wire logic                     clk_sys,      // System clock.
  input  wire logic                     sys_rst,      // Synchronous reset, active high.
  input  wire logic                     clearReq,     // Restart, disable or chip reset.
  input  wire logic                     countEn,      // Watchdog running.
  input  wire logic                     oscTick,      // One oscillator period passed.
  input  wire logic [2:0]               periodSel,    // Prescaler code.
  output logic [wd_pkg::CNT_W-1:0]      countValue,   // Present count.
  output logic                          timeoutPulse  // One-cycle expiry pulse.
);
  localparam logic [wd_pkg::CNT_W-1:0] ONE = {{(wd_pkg::CNT_W-1){1'b0}}, 1'b1};

  logic [wd_pkg::CNT_W-1:0] limit;
  logic                     hit;

  // Each code step doubles the length of the period.
  assign limit = wd_pkg::CNT_W'(TIMEOUT_BASE_P) << periodSel;
  // A shorter period chosen mid-count must not let the count run past it.
  assign hit = countEn && oscTick && !clearReq && (countValue >= limit - ONE);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clearReq || hit) begin
      countValue <= '0;
    end else if (countEn && oscTick) begin
      countValue <= countValue + ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timeoutPulse <= 1'b0;
    end else begin
      timeoutPulse <= hit;
    end
  end
endmodule
`default_nettype wire

// file: design/wd_timer.sv
// Watchdog timer with fuse-selected safety levels and an APB register slave.
// How it works
// - Time is counted in periods of a separate 1 MHz oscillator input.
// - The restart instruction pulse clears the time-out counter.
// - Disabling the watchdog or any chip reset clears the counter too.
// - An expired period with no restart raises the chip reset request.
// - Two fuses give safety level 0, 1 or 2.
// - Levels 0 and 1 start disabled; writing enable one starts freely.
// - Level 2 keeps the watchdog running and enable always reads one.
// - Control bits 7 to 5 read as zero.
// - Change-enable written one together with enable one clears itself four cycles later.
// - Enable one always taken; enable zero only while change-enable is set.
// - Level 2 never disables, even after the full sequence.
// - Level 0 takes a new prescaler value at any time.
// - Level 1 changes prescaler or disables only through the timed sequence.
// - Level 2 changes prescaler through the sequence; enable value is ignored.
// - Prescaler codes select 16,384 up to 2,097,152 oscillator cycles.
// - The expiry reset pulse lasts one system clock cycle.
// - Expiry sets the reset-source flag; power-on reset or writing zero clears it.
`timescale 1ns/1ns
`default_nettype none
module wd_timer #(
  parameter int TIMEOUT_BASE_P = wd_pkg::TIMEOUT_BASE
) (
  input  wire logic                    clk_sys,          // System clock, 50 MHz.
  input  wire logic                    sys_rst,          // Power-on reset, synchronous.
  input  wire logic                    psel,             // APB select.
  input  wire logic                    penable,          // APB access phase.
  input  wire logic                    pwrite,           // APB write.
  input  wire logic [wd_pkg::ADDR_W-1:0] paddr,          // APB byte address.
  input  wire logic [31:0]             pwdata,           // APB write data.
  output logic [31:0]                  prdata,           // APB read data.
  output logic                         pready,           // APB ready.
  output logic                         pslverr,          // APB error, unmapped address.
  input  wire logic                    wdOscClk,         // Watchdog oscillator level.
  input  wire logic                    wdRestart,        // Restart instruction pulse.
  input  wire logic                    chipRst,          // Other chip reset sources.
  input  wire logic                    legacyCompatFuse, // High while programmed.
  input  wire logic                    alwaysOnFuse,     // High while programmed.
  output logic                         wdResetPulse,     // Chip reset request.
  output logic                         wdResetSourceFlag, // Watchdog caused last reset.
  output logic                         irq               // Level interrupt.
);
  localparam logic [wd_pkg::CNT_W-1:0] ONE = {{(wd_pkg::CNT_W-1){1'b0}}, 1'b1};

  wd_pkg::safety_t           level_r;
  logic                      oscPrev_r;
  logic                      oscTick;
  logic                      enable_r;
  logic                      enEff;
  logic [2:0]                ps_r;
  logic                      windowOpen;
  logic                      resetAll;
  logic                      setupPh;
  logic                      accessPh;
  logic                      wrEn;
  logic                      ctrlWr;
  logic                      statWr;
  logic                      maskWr;
  logic                      rsrcWr;
  logic                      openWin;
  logic                      closeWin;
  logic                      wCe;
  logic                      wEn;
  logic [2:0]                wPs;
  logic                      tmoStat_r;
  logic                      tmoMask_r;
  logic [7:0]                ctrlRead;
  logic [31:0]               readWord;
  logic [wd_pkg::CNT_W-1:0]  wdCount;
  logic                      cntClear;

  // Fuses are sampled while reset is held and kept until the next reset.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level_r <= wd_pkg::level_of(legacyCompatFuse, alwaysOnFuse);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oscPrev_r <= 1'b0;
    end else begin
      oscPrev_r <= wdOscClk;
    end
  end

  // The oscillator is slow against the system clock, so one rising edge is one tick.
  assign oscTick = wdOscClk && !oscPrev_r;

  assign resetAll = chipRst || wdResetPulse;
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign wrEn     = accessPh && pwrite;
  assign ctrlWr   = wrEn && (paddr == wd_pkg::ADDR_CTRL);
  assign statWr   = wrEn && (paddr == wd_pkg::ADDR_STAT);
  assign maskWr   = wrEn && (paddr == wd_pkg::ADDR_MASK);
  assign rsrcWr   = wrEn && (paddr == wd_pkg::ADDR_RSRC);
  assign wCe      = pwdata[wd_pkg::CE_POS];
  assign wEn      = pwdata[wd_pkg::EN_POS];
  assign wPs      = pwdata[wd_pkg::PS_W-1:0];

  // Unlock needs both bits in one write, even when enable is already set.
  assign openWin  = ctrlWr && wCe && wEn;
  assign closeWin = ctrlWr && !wCe && windowOpen;

  wd_change_window u_window (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .clrReq     (resetAll),
    .openReq    (openWin),
    .closeReq   (closeWin),
    .windowOpen (windowOpen)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst || resetAll) begin
      enable_r <= 1'b0;
    end else if (ctrlWr) begin
      if (wEn) begin
        enable_r <= 1'b1;
      end else if (windowOpen && (level_r != wd_pkg::LEVEL2)) begin
        enable_r <= 1'b0;
      end
    end
  end

  assign enEff = enable_r || (level_r == wd_pkg::LEVEL2);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || resetAll) begin
      ps_r <= wd_pkg::PS_RESET;
    end else if (ctrlWr && (level_r == wd_pkg::LEVEL0)) begin
      ps_r <= wPs;
    end else if (ctrlWr && windowOpen && !wCe) begin
      ps_r <= wPs;
    end
  end

  assign cntClear = wdRestart || !enEff || chipRst;

  wd_period_counter #(
    .TIMEOUT_BASE_P (TIMEOUT_BASE_P)
  ) u_counter (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .clearReq     (cntClear),
    .countEn      (enEff),
    .oscTick      (oscTick),
    .periodSel    (ps_r),
    .countValue   (wdCount),
    .timeoutPulse (wdResetPulse)
  );

  // Expiry sets the status bit; a set in the clearing cycle wins.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tmoStat_r <= 1'b0;
    end else if (wdResetPulse) begin
      tmoStat_r <= 1'b1;
    end else if (statWr && pwdata[wd_pkg::STAT_TMO]) begin
      tmoStat_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tmoMask_r <= 1'b0;
    end else if (maskWr) begin
      tmoMask_r <= pwdata[wd_pkg::STAT_TMO];
    end
  end

  assign irq = tmoStat_r && tmoMask_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wdResetSourceFlag <= 1'b0;
    end else if (wdResetPulse) begin
      wdResetSourceFlag <= 1'b1;
    end else if (rsrcWr && !pwdata[wd_pkg::RSRC_WD]) begin
      wdResetSourceFlag <= 1'b0;
    end
  end

  assign ctrlRead = {3'h0, windowOpen, enEff, ps_r};

  always_comb begin
    readWord = 32'h0000_0000;
    unique case (paddr)
      wd_pkg::ADDR_CTRL: begin
        readWord = {24'h00_0000, ctrlRead};
      end
      wd_pkg::ADDR_STAT: begin
        readWord = {31'h0000_0000, tmoStat_r};
      end
      wd_pkg::ADDR_MASK: begin
        readWord = {31'h0000_0000, tmoMask_r};
      end
      wd_pkg::ADDR_RSRC: begin
        readWord = {31'h0000_0000, wdResetSourceFlag};
      end
      default: begin
        readWord = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured in the setup cycle and stands through the access.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh && !pwrite) begin
      prdata <= readWord;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = accessPh && !wd_pkg::is_mapped(paddr);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  AST_TICK_ONLY: assert property (
    !oscTick |=> (wdCount == '0) || (wdCount == $past(wdCount))
  ) else $error("watchdog count moved without an oscillator tick");

  AST_RESTART_CLEARS: assert property (
    wdRestart |=> (wdCount == '0) && !wdResetPulse
  ) else $error("restart did not clear the watchdog count");

  AST_DISABLE_CLEARS: assert property (
    (!enEff || chipRst) |=> (wdCount == '0)
  ) else $error("disabled or reset watchdog kept a count");

  AST_EXPIRY_AT_LIMIT: assert property (
    wdResetPulse |-> $past(enEff) && $past(oscTick) &&
      ($past(wdCount) >= ((wd_pkg::CNT_W'(TIMEOUT_BASE_P) << $past(ps_r)) - ONE))
  ) else $error("reset request raised before the period elapsed");

  AST_PULSE_ONE: assert property (
    wdResetPulse |=> !wdResetPulse && wdResetSourceFlag
  ) else $error("reset pulse longer than one cycle or flag not set");

  AST_LEVEL2_READ: assert property (
    (level_r == wd_pkg::LEVEL2) && setupPh && !pwrite && (paddr == wd_pkg::ADDR_CTRL)
      |=> prdata[wd_pkg::EN_POS]
  ) else $error("enable bit read as zero in level 2");

  AST_RSVD_ZERO: assert property (
    accessPh && !pwrite && (paddr == wd_pkg::ADDR_CTRL) |-> (prdata[7:5] == 3'h0)
  ) else $error("reserved control bits read as one");

  AST_WIN_HELD: assert property (
    openWin && !resetAll ##1 (!ctrlWr && !resetAll) [*3] |-> windowOpen
  ) else $error("change window closed early");

  AST_WIN_CLOSES: assert property (
    openWin && !resetAll ##1 (!ctrlWr && !resetAll) [*5] |-> !windowOpen
  ) else $error("change window stayed open past four cycles");

  AST_NO_FREE_DISABLE: assert property (
    enable_r && !windowOpen && !resetAll |=> enable_r
  ) else $error("watchdog disabled without the timed sequence");

  AST_SET_ENABLE: assert property (
    ctrlWr && wEn && !resetAll |=> enable_r && enEff
  ) else $error("enable write of one was not taken");

  AST_LVL0_PS: assert property (
    ctrlWr && (level_r == wd_pkg::LEVEL0) && !resetAll |=> (ps_r == $past(wPs))
  ) else $error("level 0 prescaler write was not taken");

  AST_PS_LOCKED: assert property (
    ctrlWr && (level_r != wd_pkg::LEVEL0) && !windowOpen && !resetAll |=> $stable(ps_r)
  ) else $error("protected prescaler changed outside the window");

  AST_LVL2_KEEPS: assert property (
    (level_r == wd_pkg::LEVEL2) |-> enEff && (!cntClear || wdRestart || chipRst)
  ) else $error("level 2 watchdog stopped");

  AST_WIN_DISABLE: assert property (
    ctrlWr && !wEn && windowOpen && (level_r != wd_pkg::LEVEL2) && !resetAll |=> !enable_r
  ) else $error("in-window disable write was not taken");

  AST_EXPIRY_STATUS: assert property (
    wdResetPulse |=> tmoStat_r
  ) else $error("expiry did not set the status bit");

  AST_FLAG_CLEAR: assert property (
    rsrcWr && !pwdata[wd_pkg::RSRC_WD] && !wdResetPulse |=> !wdResetSourceFlag
  ) else $error("reset-source flag not cleared by a zero write");

  COV_DISABLE_SEQ: cover property (
    openWin ##[1:4] (ctrlWr && !wEn && windowOpen) ##1 !enable_r
  );
  COV_EXPIRY: cover property (wdResetPulse);
  COV_LVL2_PS: cover property (
    (level_r == wd_pkg::LEVEL2) && openWin ##[1:4] closeWin
  );
  COV_IRQ: cover property (irq);
endmodule
`default_nettype wire

// file: dv/watchdog_timer_safety_levels_bench.sv
// Self-checking bench for the watchdog timer with fuse-selected safety levels.
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer_safety_levels_bench;
  localparam int BASE = 4;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wdOscClk = 1'b0;
  logic        wdRestart = 1'b0;
  logic        chipRst = 1'b0;
  logic        legacyCompatFuse = 1'b0;
  logic        alwaysOnFuse = 1'b0;
  logic        wdResetPulse;
  logic        wdResetSourceFlag;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  d;
  int          errTotal = 0;
  int          nCompared = 0;
  int          oscRises = 0;
  int          oscDiv = 0;
  int          nPulse = 0;
  int          mLvl;
  int          mEn;
  int          mPs;

  wd_timer #(.TIMEOUT_BASE_P(BASE)) wd_timer_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdOscClk(wdOscClk), .wdRestart(wdRestart), .chipRst(chipRst),
    .legacyCompatFuse(legacyCompatFuse), .alwaysOnFuse(alwaysOnFuse),
    .wdResetPulse(wdResetPulse), .wdResetSourceFlag(wdResetSourceFlag), .irq(irq));

  always #10 clk_sys = ~clk_sys;

  // Oscillator of 1 MHz made from the 50 MHz clock, its rising edges counted.
  always @(posedge clk_sys) begin
    if (oscDiv == 24) begin
      oscDiv   <= 0;
      wdOscClk <= ~wdOscClk;
      if (!wdOscClk) oscRises <= oscRises + 1;
    end else begin
      oscDiv <= oscDiv + 1;
    end
  end

  always @(negedge clk_sys) if (wdResetPulse === 1'b1) nPulse++;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      errTotal++;
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One transfer; the select stays up so that a second one may follow at once.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errTotal++;
    rd  = prdata;
    err = pslverr;
  endtask

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wctl(input logic [7:0] v, input bit inWin);
    bus(1'b1, wd_pkg::ADDR_CTRL, {24'h000000, v});
    if (v[3]) mEn = 1;
    else if (inWin && mLvl != 2) mEn = 0;
    if (mLvl == 0 || (inWin && !v[4])) mPs = v[2:0];
  endtask

  task automatic rctl(input bit ce);
    bus(1'b0, wd_pkg::ADDR_CTRL, 32'h00000000);
    chk("control", rd, {27'h0, ce, mEn == 1 || mLvl == 2, mPs[2:0]});
  endtask

  task automatic doReset(input logic cf, input logic ao);
    legacyCompatFuse <= cf;
    alwaysOnFuse     <= ao;
    sys_rst          <= 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    mLvl = ao ? 2 : (cf ? 0 : 1);
    mEn  = (mLvl == 2);
    mPs  = 0;
  endtask

  // Waits for the reset request and checks its distance in oscillator ticks.
  task automatic expire(input int ticks);
    int base;
    int n;
    base = oscRises;
    n    = 0;
    while (wdResetPulse !== 1'b1 && n < 30000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("ticks to expiry", oscRises - base, ticks);
    @(negedge clk_sys);
    chk("pulse width", wdResetPulse, 32'h0);
    @(posedge clk_sys);
    chk("source flag", wdResetSourceFlag, 32'h1);
    chk("interrupt", irq, 32'h1);
    mPs = 0;
    if (mLvl != 2) mEn = 0;
    rctl(1'b0);
    bus(1'b1, wd_pkg::ADDR_STAT, 32'h00000001);
    bus(1'b1, wd_pkg::ADDR_RSRC, 32'h00000000);
    idle();
    chk("interrupt cleared", irq, 32'h0);
    chk("flag cleared", wdResetSourceFlag, 32'h0);
  endtask

  task automatic restart();
    wdRestart <= 1'b1;
    @(posedge clk_sys);
    wdRestart <= 1'b0;
  endtask

  initial begin
    repeat (95000) @(posedge clk_sys);
    errTotal++;
    summarize();
  end

  initial begin
    void'($urandom(32'h5C93501F));
    doReset(1'b0, 1'b0);
    for (int i = 4; i < 16; i += 4) begin
      bus(1'b0, i[11:0], 32'h00000000);
      chk("status reset", rd, 32'h0);
    end
    rctl(1'b0);
    bus(1'b0, 12'h010, 32'h00000000);
    chk("unmapped error", err, 32'h1);
    wctl(8'h0B, 1'b0);
    rctl(1'b0);
    wctl(8'h00, 1'b0);
    rctl(1'b0);
    wctl(8'h18, 1'b0);
    rctl(1'b1);
    wctl(8'h0B, 1'b1);
    rctl(1'b0);
    wctl(8'h18, 1'b0);
    idle();
    repeat (4) @(posedge clk_sys);
    rctl(1'b0);
    wctl(8'h00, 1'b0);
    rctl(1'b0);
    wctl(8'h18, 1'b0);
    wctl(8'h00, 1'b1);
    rctl(1'b0);
    bus(1'b1, wd_pkg::ADDR_MASK, 32'h00000001);
    wctl(8'h08, 1'b0);
    idle();
    repeat (8) begin
      repeat (100) @(posedge clk_sys);
      restart();
    end
    chk("no expiry while restarted", nPulse, 32'h0);
    expire(BASE);
    wctl(8'h08, 1'b0);
    idle();
    chipRst <= 1'b1;
    @(posedge clk_sys);
    chipRst <= 1'b0;
    mEn = 0;
    rctl(1'b0);
    idle();
    doReset(1'b1, 1'b0);
    rctl(1'b0);
    repeat (4) begin
      d = 8'($urandom) & 8'hE7 | 8'h08;
      wctl(d, 1'b0);
      rctl(1'b0);
    end
    bus(1'b1, wd_pkg::ADDR_MASK, 32'h00000001);
    for (int k = 0; k < 8; k++) begin
      wctl(8'h08 | k[7:0], 1'b0);
      idle();
      restart();
      expire(BASE << k);
    end
    doReset(1'b0, 1'b1);
    rctl(1'b0);
    wctl(8'h00, 1'b0);
    wctl(8'h18, 1'b0);
    wctl(8'h05, 1'b1);
    rctl(1'b0);
    wctl(8'h18, 1'b0);
    wctl(8'h00, 1'b1);
    rctl(1'b0);
    bus(1'b1, wd_pkg::ADDR_MASK, 32'h00000001);
    idle();
    restart();
    expire(BASE);
    summarize();
  end
endmodule
`default_nettype wire
